// ==== rak_host_model.sv ====
// Controller model that drives the modulation pins of the block.
// Assumes the bench calls its tasks from the aclk domain.
`timescale 1ns/1ps
`default_nettype none

module rak_host_model (
  input wire logic aclk,
  output var logic ramp_direction_pin,
  output var logic ramp_hold_pin,
  output var logic amplitude_keying_pin,
  output var logic io_update_pin,
  output var logic [2:0] profile_pin
);
  initial begin
    ramp_direction_pin = 1'b0;
    ramp_hold_pin = 1'b0;
    amplitude_keying_pin = 1'b0;
    io_update_pin = 1'b0;
    profile_pin = 3'h0;
  end

  task automatic pins(input logic d, input logic h, input logic k, input logic [2:0] p);
    @(posedge aclk);
    ramp_direction_pin <= d;
    ramp_hold_pin <= h;
    amplitude_keying_pin <= k;
    profile_pin <= p;
  endtask

  // Pulse long enough to pass the two-stage synchroniser
  task automatic update();
    @(posedge aclk);
    io_update_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    io_update_pin <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ==== rak_map.vh ====
// Register map, field positions, reset values and timing counts of the
// ramp and amplitude keying block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef RAK_MAP_VH
`define RAK_MAP_VH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define RAK_ADDR_CTRL1 8'h00
`define RAK_ADDR_CTRL2 8'h04
`define RAK_ADDR_UPPER 8'h08
`define RAK_ADDR_LOWER 8'h0c
`define RAK_ADDR_RISE_STEP 8'h10
`define RAK_ADDR_FALL_STEP 8'h14
`define RAK_ADDR_RATE 8'h18
`define RAK_ADDR_STATUS 8'h1c
`define RAK_ADDR_RAMP_VALUE 8'h20
`define RAK_ADDR_LAST_PLAIN 8'h20
`define RAK_ADDR_PROF_BASE 8'h40
`define RAK_ADDR_PROF_LAST 8'h7c

// ---------------------------------------------------------------
// Control word one fields
// ---------------------------------------------------------------
`define RAK_KEY_EN_BIT 8
`define RAK_KEY_EXT_BIT 9
`define RAK_LOAD_RATE_BIT 15

// ---------------------------------------------------------------
// Control word two fields
// ---------------------------------------------------------------
`define RAK_CLEAR_BIT 14
`define RAK_NODWELL_LO 17
`define RAK_NODWELL_HI 18
`define RAK_RAMP_EN_BIT 19
`define RAK_DEST_LO 20
`define RAK_DEST_HI 21

// ---------------------------------------------------------------
// Rate word and profile word fields
// ---------------------------------------------------------------
`define RAK_RATE_P_LO 0
`define RAK_RATE_P_HI 15
`define RAK_RATE_N_LO 16
`define RAK_RATE_N_HI 31
`define RAK_PHASE_LO 0
`define RAK_PHASE_HI 15
`define RAK_AMP_LO 16
`define RAK_AMP_HI 27

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RAK_CTRL1_RST 32'h00000000
`define RAK_CTRL2_RST 32'h00000000
`define RAK_UPPER_RST 32'hffffffff
`define RAK_LOWER_RST 32'h00000000
`define RAK_STEP_RST 32'h00000001
`define RAK_RATE_RST 32'h00010001

// ---------------------------------------------------------------
// Timing: system clock periods per synthesis clock period
// ---------------------------------------------------------------
`define RAK_SYNTH_DIV 24

`endif

// ==== rak_pin_sync.v ====
// Two-stage synchroniser with edge detection for a group of pins.
// Assumes asynchronous pins and a single system clock.
`timescale 1ns/1ps
`default_nettype none

module rak_pin_sync #(
  parameter WIDTH = 7
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] pin,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta;
      reg stable;
      reg last;
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta <= 1'b0;
          stable <= 1'b0;
          last <= 1'b0;
        end else begin
          meta <= pin[i];
          stable <= meta;
          last <= stable;
        end
      end
      assign level[i] = stable;
      assign rise[i] = stable & ~last;
      assign fall[i] = ~stable & last;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== rak_ramp_keying.v ====
// Ramp generator and amplitude keying stage with an AXI4-Lite register port.
// Assumes pins from outside the clock domain and an AXI4-Lite master on aclk.
//
// Contract
// - Enabled keying overrides every other amplitude source
// - Keying disabled ignores keying pin and controls
// - External keying: pin low zero, high scale
// - Profile pins pick one of eight scale factors
// - Ramp disabled ignores controls, stops its clocks
// - Destination bits route ramp to frequency/phase/amplitude
// - Unused upper ramp bits ignored for phase/amplitude
// - Separate limits, rise/fall step sizes and intervals
// - Hold pin high freezes the ramp
// - Non-destination parameters come from active profile
// - No-dwell 00: direction pin level sensitive, hold limit
// - No-dwell 01: falling edge one-shot, return upper
// - No-dwell 10: rising edge one-shot, return lower
// - No-dwell 11: continuous, edges reverse direction immediately
// - Ramp control changes wait for update pin
// - Ramp output stays within upper and lower limits
// - Step interval is 24 times rate timer value
`timescale 1ns/1ps
`default_nettype none
`include "rak_map.vh"

module rak_ramp_keying #(
  parameter SYNTH_DIV = `RAK_SYNTH_DIV,
  parameter PROFILES = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ramp_direction_pin,
  input wire ramp_hold_pin,
  input wire amplitude_keying_pin,
  input wire io_update_pin,
  input wire [2:0] profile_pin,
  output reg [31:0] freq_word,
  output reg [15:0] phase_word,
  output reg [11:0] amp_word
);

  localparam [1:0] RESP_OKAY = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;
  localparam [1:0] MODE_HOLD = 2'b00;
  localparam [1:0] MODE_FALL_SHOT = 2'b01;
  localparam [1:0] MODE_RISE_SHOT = 2'b10;
  localparam [1:0] MODE_CONT = 2'b11;
  localparam [4:0] DIV_LAST = SYNTH_DIV[4:0] - 5'h01;

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  wire [6:0] pin_level;
  wire [6:0] pin_rise;
  wire [6:0] pin_fall;

  rak_pin_sync #(.WIDTH(7)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({profile_pin, io_update_pin, amplitude_keying_pin, ramp_hold_pin,
          ramp_direction_pin}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  wire dir_level = pin_level[0];
  wire dir_rise = pin_rise[0];
  wire dir_fall = pin_fall[0];
  wire hold_level = pin_level[1];
  wire key_level = pin_level[2];
  wire update = pin_rise[3];
  wire [2:0] profile_sel = pin_level[6:4];

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  reg [31:0] ctrl1;
  reg [31:0] ctrl2;
  reg [31:0] ctrl2_act;
  reg [31:0] upper;
  reg [31:0] lower;
  reg [31:0] rise_step;
  reg [31:0] fall_step;
  reg [31:0] rate;
  reg [31:0] prof_freq [0:PROFILES-1];
  reg [31:0] prof_pa [0:PROFILES-1];

  reg [31:0] acc;
  reg ramp_up;
  reg busy;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr <= `RAK_ADDR_LAST_PLAIN) ||
               (addr >= `RAK_ADDR_PROF_BASE && addr <= `RAK_ADDR_PROF_LAST);
    end
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  reg [7:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire [7:0] wr_word = {wr_addr[7:2], 2'b00};
  wire [2:0] wr_prof = wr_word[5:3];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wr_word) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1 <= `RAK_CTRL1_RST;
      ctrl2 <= `RAK_CTRL2_RST;
      upper <= `RAK_UPPER_RST;
      lower <= `RAK_LOWER_RST;
      rise_step <= `RAK_STEP_RST;
      fall_step <= `RAK_STEP_RST;
      rate <= `RAK_RATE_RST;
    end else if (wr_go) begin
      case (wr_word)
        `RAK_ADDR_CTRL1: ctrl1 <= merge(ctrl1, wr_data, wr_strb);
        `RAK_ADDR_CTRL2: ctrl2 <= merge(ctrl2, wr_data, wr_strb);
        `RAK_ADDR_UPPER: upper <= merge(upper, wr_data, wr_strb);
        `RAK_ADDR_LOWER: lower <= merge(lower, wr_data, wr_strb);
        `RAK_ADDR_RISE_STEP: rise_step <= merge(rise_step, wr_data, wr_strb);
        `RAK_ADDR_FALL_STEP: fall_step <= merge(fall_step, wr_data, wr_strb);
        `RAK_ADDR_RATE: rate <= merge(rate, wr_data, wr_strb);
        default: ;
      endcase
    end
  end

  // Profile words: freq at base + 8*i, phase and scale at base + 8*i + 4
  genvar p;
  generate
    for (p = 0; p < PROFILES; p = p + 1) begin : g_prof
      always @(posedge aclk) begin
        if (!aresetn) begin
          prof_freq[p] <= 32'h00000000;
          prof_pa[p] <= 32'h00000000;
        end else if (wr_go && wr_word[7:6] == 2'b01 && wr_prof == p) begin
          if (wr_word[2]) begin
            prof_pa[p] <= merge(prof_pa[p], wr_data, wr_strb);
          end else begin
            prof_freq[p] <= merge(prof_freq[p], wr_data, wr_strb);
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  wire [7:0] rd_word = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] ramp_lim;
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (rd_word)
      `RAK_ADDR_CTRL1: rd_mux = ctrl1;
      `RAK_ADDR_CTRL2: rd_mux = ctrl2;
      `RAK_ADDR_UPPER: rd_mux = upper;
      `RAK_ADDR_LOWER: rd_mux = lower;
      `RAK_ADDR_RISE_STEP: rd_mux = rise_step;
      `RAK_ADDR_FALL_STEP: rd_mux = fall_step;
      `RAK_ADDR_RATE: rd_mux = rate;
      `RAK_ADDR_STATUS: rd_mux = {24'h000000, profile_sel, busy, ramp_up,
                                  hold_level, key_level, ctrl2_act[`RAK_RAMP_EN_BIT]};
      `RAK_ADDR_RAMP_VALUE: rd_mux = ramp_lim;
      default: begin
        if (rd_word[7:6] == 2'b01) begin
          rd_mux = rd_word[2] ? prof_pa[rd_word[5:3]] : prof_freq[rd_word[5:3]];
        end
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= mapped(rd_word) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Ramp control registered on update
  // ---------------------------------------------------------------
  wire ramp_en = ctrl2_act[`RAK_RAMP_EN_BIT];
  wire ramp_clear = ctrl2_act[`RAK_CLEAR_BIT];
  wire [1:0] mode = ctrl2_act[`RAK_NODWELL_HI:`RAK_NODWELL_LO];
  wire [1:0] dest = ctrl2_act[`RAK_DEST_HI:`RAK_DEST_LO];
  wire en_start = update && ctrl2[`RAK_RAMP_EN_BIT] && !ramp_en;
  wire rate_load = update && ctrl1[`RAK_LOAD_RATE_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl2_act <= `RAK_CTRL2_RST;
    end else if (update) begin
      ctrl2_act <= ctrl2;
    end
  end

  // ---------------------------------------------------------------
  // Synthesis clock enable and step timer
  // ---------------------------------------------------------------
  reg [4:0] div_cnt;
  reg [15:0] tmr;
  wire synth_tick = ramp_en && (div_cnt == DIV_LAST);
  wire [15:0] interval = ramp_up ? rate[`RAK_RATE_P_HI:`RAK_RATE_P_LO]
                                 : rate[`RAK_RATE_N_HI:`RAK_RATE_N_LO];
  wire [15:0] tmr_next = tmr + 16'h0001;
  wire tmr_reload = en_start || dir_rise || dir_fall || rate_load;
  wire step_now = synth_tick && !hold_level && !ramp_clear && !tmr_reload &&
                  (tmr_next >= interval);

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 5'h00;
      tmr <= 16'h0000;
    end else if (!ramp_en) begin
      div_cnt <= 5'h00;
      tmr <= 16'h0000;
    end else begin
      if (!hold_level) begin
        div_cnt <= synth_tick ? 5'h00 : div_cnt + 5'h01;
      end
      if (tmr_reload) begin
        tmr <= 16'h0000;
      end else if (step_now) begin
        tmr <= 16'h0000;
      end else if (synth_tick && !hold_level) begin
        tmr <= tmr_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // Ramp accumulator and direction
  // ---------------------------------------------------------------
  wire [32:0] up_sum = {1'b0, acc} + {1'b0, rise_step};
  wire [32:0] low_sum = {1'b0, lower} + {1'b0, fall_step};
  wire hit_upper = up_sum >= {1'b0, upper};
  wire hit_lower = {1'b0, acc} <= low_sum;
  wire [31:0] acc_up = hit_upper ? upper : up_sum[31:0];
  wire [31:0] acc_down = hit_lower ? lower : acc - fall_step;
  wire shot = (mode == MODE_FALL_SHOT) || (mode == MODE_RISE_SHOT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      acc <= 32'h00000000;
      ramp_up <= 1'b0;
      busy <= 1'b0;
    end else if (en_start) begin
      acc <= (ctrl2[`RAK_NODWELL_HI:`RAK_NODWELL_LO] == MODE_FALL_SHOT) ? upper : lower;
      ramp_up <= dir_level;
      busy <= 1'b0;
    end else if (!ramp_en || hold_level) begin
      acc <= acc;
    end else if (ramp_clear) begin
      acc <= lower;
      busy <= 1'b0;
    end else begin
      case (mode)
        MODE_HOLD: begin
          ramp_up <= dir_level;
          if (step_now) begin
            acc <= ramp_up ? acc_up : acc_down;
          end
        end
        MODE_FALL_SHOT: begin
          if (!busy) begin
            if (dir_fall) begin
              busy <= 1'b1;
              ramp_up <= 1'b0;
            end
          end else if (step_now) begin
            acc <= hit_lower ? upper : acc_down;
            busy <= !hit_lower;
          end
        end
        MODE_RISE_SHOT: begin
          if (!busy) begin
            if (dir_rise) begin
              busy <= 1'b1;
              ramp_up <= 1'b1;
            end
          end else if (step_now) begin
            acc <= hit_upper ? lower : acc_up;
            busy <= !hit_upper;
          end
        end
        MODE_CONT: begin
          if (ramp_up && dir_fall) begin
            ramp_up <= 1'b0;
          end else if (!ramp_up && dir_rise) begin
            ramp_up <= 1'b1;
          end else if (step_now) begin
            acc <= ramp_up ? acc_up : acc_down;
            if (ramp_up && hit_upper) begin
              ramp_up <= 1'b0;
            end else if (!ramp_up && hit_lower) begin
              ramp_up <= 1'b1;
            end
          end
        end
        default: acc <= acc;
      endcase
      if (!shot) begin
        busy <= 1'b0;
      end
    end
  end

  // Limits reprogrammed under a running ramp still bound the output
  assign ramp_lim = (acc > upper) ? upper : (acc < lower) ? lower : acc;

  // ---------------------------------------------------------------
  // Parameter routing and amplitude keying
  // ---------------------------------------------------------------
  wire [31:0] cur_pa = prof_pa[profile_sel];
  wire [11:0] prof_scale = cur_pa[`RAK_AMP_HI:`RAK_AMP_LO];
  wire key_en = ctrl1[`RAK_KEY_EN_BIT];
  wire key_ext = ctrl1[`RAK_KEY_EXT_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      freq_word <= 32'h00000000;
      phase_word <= 16'h0000;
      amp_word <= 12'h000;
    end else begin
      if (ramp_en && dest == 2'b00) begin
        freq_word <= ramp_lim;
      end else begin
        freq_word <= prof_freq[profile_sel];
      end
      if (ramp_en && dest == 2'b01) begin
        phase_word <= ramp_lim[15:0];
      end else begin
        phase_word <= cur_pa[`RAK_PHASE_HI:`RAK_PHASE_LO];
      end
      if (key_en) begin
        amp_word <= (key_ext && !key_level) ? 12'h000 : prof_scale;
      end else if (ramp_en && dest[1]) begin
        amp_word <= ramp_lim[11:0];
      end else begin
        amp_word <= prof_scale;
      end
    end
  end

endmodule

`default_nettype wire

// ==== rak_ramp_keying_assertions.sv ====
// Checker for the ramp and amplitude keying block, bound to its top module.
// Assumes full-word AXI writes that offer address and data together.
`timescale 1ns/1ps
`default_nettype none

module rak_ramp_keying_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic amplitude_keying_pin,
  input wire logic [31:0] freq_word,
  input wire logic [11:0] amp_word
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------
  // Shadow of control word one
  // ---------------------------------------------------------------
  logic [1:0] key_bits;
  wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_bits <= 2'b00;
    end else if (wr_take && s_axi_awaddr == 8'h00) begin
      key_bits <= s_axi_wdata[9:8];
    end
  end

  AST_B_AFTER_WRITE: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response missing");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_W_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_R_AFTER_READ: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_UNMAPPED_READ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h30
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  AST_RESET_OUTS: assert property ($rose(aresetn) |-> freq_word == 32'h0 && amp_word == 12'h0)
    else $error("outputs not cleared by reset");
  AST_KEY_ZERO: assert property ((key_bits == 2'b11 && !amplitude_keying_pin) [*4]
    |=> amp_word == 12'h000)
    else $error("keyed amplitude not zero");

  cover property (wr_take);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  cover property (key_bits == 2'b11 && amp_word == 12'h000);
endmodule

bind rak_ramp_keying rak_ramp_keying_assertions chk_u (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .amplitude_keying_pin, .freq_word, .amp_word);
`default_nettype wire

// ==== rak_ramp_keying_tb.sv ====
// Self-checking bench for the ramp and amplitude keying block.
// Assumes the host model drives the pins; the AXI master lives here.
`timescale 1ns/1ps
`default_nettype none
`include "rak_map.vh"

module rak_ramp_keying_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, got;
  logic [1:0] resp;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, freq_word;
  wire logic [15:0] phase_word;
  wire logic [11:0] amp_word;
  wire logic ramp_direction_pin, ramp_hold_pin, amplitude_keying_pin, io_update_pin;
  wire logic [2:0] profile_pin;
  int n_errors = 0;
  int num_checks = 0;
  int gap_n;
  localparam logic [31:0] LO = 32'h00030100;
  localparam logic [31:0] HI = 32'h00030200;
  localparam logic [31:0] F0 = 32'h12345678;

  rak_ramp_keying #(.SYNTH_DIV(2)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ramp_direction_pin, .ramp_hold_pin, .amplitude_keying_pin,
    .io_update_pin, .profile_pin, .freq_word, .phase_word, .amp_word);
  rak_host_model host_u (.aclk, .ramp_direction_pin, .ramp_hold_pin, .amplitude_keying_pin,
    .io_update_pin, .profile_pin);

  // ---------------------------------------------------------------
  // Bus and check helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic c2(input logic [31:0] v);
    wr(`RAK_ADDR_CTRL2, v);
    host_u.update();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Cycles between two successive changes of the frequency output
  task automatic gap();
    logic [31:0] v;
    int n;
    n = 0;
    v = freq_word;
    while (freq_word === v && n < 100) begin
      @(posedge aclk);
      n++;
    end
    v = freq_word;
    n = 0;
    while (freq_word === v && n < 100) begin
      @(posedge aclk);
      n++;
    end
    gap_n = n;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd(`RAK_ADDR_UPPER);
    chk(got, `RAK_UPPER_RST);
    rd(`RAK_ADDR_RATE);
    chk(got, `RAK_RATE_RST);
    rd(8'h30);
    chk({got[31:2], resp}, {30'h0, 2'b10});
    wr(8'h30, 32'h5);
    chk({30'h0, resp}, 32'h2);
  endtask

  task automatic t_key();
    for (int i = 0; i < 8; i++) begin
      wr(8'h44 + 8'(i * 8), {4'h0, 12'(12'h111 * (i + 1)), 16'h0});
    end
    wr(`RAK_ADDR_CTRL1, 32'h300);
    for (int i = 0; i < 8; i++) begin
      host_u.pins(1'b0, 1'b0, 1'b1, 3'(i));
      cyc(6);
      chk({20'h0, amp_word}, {20'h0, 12'(12'h111 * (i + 1))});
    end
    host_u.pins(1'b0, 1'b0, 1'b0, 3'h1);
    cyc(6);
    chk({20'h0, amp_word}, 32'h0);
    wr(`RAK_ADDR_CTRL1, 32'h200);
    cyc(4);
    chk({20'h0, amp_word}, 32'h222);
    wr(`RAK_ADDR_CTRL1, 32'h0);
    host_u.pins(1'b0, 1'b0, 1'b0, 3'h0);
  endtask

  task automatic t_ramp();
    wr(`RAK_ADDR_PROF_BASE, F0);
    wr(`RAK_ADDR_UPPER, HI);
    wr(`RAK_ADDR_LOWER, LO);
    wr(`RAK_ADDR_RISE_STEP, 32'h40);
    wr(`RAK_ADDR_FALL_STEP, 32'h40);
    wr(`RAK_ADDR_RATE, 32'h00040001);
    wr(`RAK_ADDR_CTRL2, 32'h00080000);
    cyc(20);
    chk(freq_word, F0);
    host_u.update();
    cyc(20);
    chk(freq_word, LO);
    host_u.pins(1'b1, 1'b0, 1'b0, 3'h0);
    cyc(40);
    chk(freq_word, HI);
    host_u.pins(1'b0, 1'b1, 1'b0, 3'h0);
    cyc(40);
    chk(freq_word, HI);
    host_u.pins(1'b0, 1'b0, 1'b0, 3'h0);
    gap();
    chk(gap_n, 32'd8);
    cyc(60);
    chk(freq_word, LO);
    c2(32'h0);
    host_u.pins(1'b1, 1'b0, 1'b0, 3'h0);
    cyc(10);
    chk(freq_word, F0);
    host_u.pins(1'b0, 1'b0, 1'b0, 3'h0);
  endtask

  task automatic t_dest();
    c2(32'h00180000);
    cyc(10);
    chk({16'h0, phase_word}, {16'h0, LO[15:0]});
    chk(freq_word, F0);
    c2(32'h00280000);
    cyc(10);
    chk({20'h0, amp_word}, {20'h0, LO[11:0]});
    wr(`RAK_ADDR_CTRL1, 32'h100);
    cyc(4);
    chk({20'h0, amp_word}, 32'h111);
    wr(`RAK_ADDR_CTRL1, 32'h0);
    c2(32'h0);
  endtask

  task automatic t_shot(input logic [1:0] nd);
    logic [31:0] s;
    s = nd[0] ? HI : LO;
    host_u.pins(nd[0], 1'b0, 1'b0, 3'h0);
    c2(32'h00080000 | {11'h0, 2'b00, nd, 17'h0});
    cyc(10);
    chk(freq_word, s);
    host_u.pins(!nd[0], 1'b0, 1'b0, 3'h0);
    cyc(20);
    chk({31'h0, freq_word !== s}, 32'h1);
    host_u.pins(nd[0], 1'b0, 1'b0, 3'h0);
    cyc(60);
    chk(freq_word, s);
    c2(32'h0);
  endtask

  task automatic t_cont();
    host_u.pins(1'b1, 1'b0, 1'b0, 3'h0);
    c2(32'h000e0000);
    rd(`RAK_ADDR_STATUS);
    chk(got, 32'h9);
    host_u.pins(1'b0, 1'b0, 1'b0, 3'h0);
    cyc(4);
    rd(`RAK_ADDR_STATUS);
    chk(got, 32'h1);
    c2(32'h0);
  endtask

  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_key();
    t_ramp();
    t_dest();
    wr(`RAK_ADDR_RATE, 32'h00040004);
    t_shot(2'b01);
    t_shot(2'b10);
    t_cont();
    end_sim();
  end

  initial begin
    #2000000;
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
